// [verilog/smg_pkg.sv]
package smg_pkg;

  // register index space: byte address on the bus is four times the index
  localparam int          IDX_W         = 12;
  localparam logic [11:0] IDX_LAST      = 12'h8ff;
  localparam logic [11:0] SEC_GL_LO     = 12'h000;
  localparam logic [11:0] SEC_AR_LO     = 12'h040;
  localparam logic [11:0] SEC_BE_LO     = 12'h080;
  localparam logic [11:0] SEC_SI_LO     = 12'h0c0;
  localparam logic [11:0] SEC_EI_LO     = 12'h140;
  localparam logic [11:0] SEC_UNUSED_LO = 12'h180;
  localparam int          SEC_BYTES     = 64;

  // global section offsets
  localparam logic [5:0] OFS_ID_LOW      = 6'h00;
  localparam logic [5:0] OFS_ID_HIGH     = 6'h01;
  localparam logic [5:0] OFS_GCTRL       = 6'h02;
  localparam logic [5:0] OFS_LED         = 6'h03;
  localparam logic [5:0] OFS_LINE_ACT    = 6'h04;
  localparam logic [5:0] OFS_SREF_ACT    = 6'h05;
  localparam logic [5:0] OFS_LINE_IE     = 6'h06;
  localparam logic [5:0] OFS_LINE_IS     = 6'h07;
  localparam logic [5:0] OFS_SUB_IE      = 6'h08;
  localparam logic [5:0] OFS_SUB_IS      = 6'h09;
  localparam logic [5:0] OFS_QUE_IE      = 6'h0a;
  localparam logic [5:0] OFS_QUE_IS      = 6'h0b;
  localparam logic [5:0] OFS_BT_IE       = 6'h0c;
  localparam logic [5:0] OFS_BT_IS       = 6'h0d;
  localparam logic [5:0] OFS_CONNECT     = 6'h0e;
  localparam logic [5:0] OFS_QPRIO       = 6'h12;
  localparam logic [5:0] OFS_LINK_CFG    = 6'h30;
  localparam logic [5:0] OFS_STRAP_STAT  = 6'h31;
  localparam logic [5:0] OFS_ST_EN       = 6'h20;
  localparam logic [5:0] OFS_ST_RES      = 6'h21;
  localparam logic [5:0] OFS_SD_BURST    = 6'h3a;
  localparam logic [5:0] OFS_SD_LAT      = 6'h3b;
  localparam logic [5:0] OFS_SD_WS       = 6'h3c;
  localparam logic [5:0] OFS_SD_REF      = 6'h3d;

  // writable masks and field positions
  localparam logic [7:0] MSK_GCTRL   = 8'h07;
  localparam logic [7:0] MSK_BIT0    = 8'h01;
  localparam logic [7:0] MSK_BIT40   = 8'h11;
  localparam logic [7:0] MSK_QPRIO   = 8'h0f;
  localparam logic [7:0] MSK_SD_LAT  = 8'h07;
  localparam logic [7:0] MSK_LINKCFG = 8'h1f;
  localparam logic [7:0] MSK_ALL     = 8'hff;
  localparam logic [7:0] RST_VALUE   = 8'h00;
  localparam int GC_SOFT_RST = 0;
  localparam int GC_IRQ_MASK = 1;
  localparam int GC_REFCLK   = 2;

  // hardware-mode transmit queue size codes
  localparam logic [7:0] TXQ_640 = 8'h14;
  localparam logic [7:0] TXQ_768 = 8'h18;

  typedef enum logic [2:0] {
    SMG_SEC_GLOBAL  = 3'b000,
    SMG_SEC_ARBITER = 3'b001,
    SMG_SEC_BERT    = 3'b010,
    SMG_SEC_SERIAL  = 3'b011,
    SMG_SEC_ETHER   = 3'b100,
    SMG_SEC_NONE    = 3'b111
  } smg_sec_t;

  typedef struct packed {
    logic rmii;
    logic dce;
    logic laps_en;
    logic scramble_en;
    logic lsb_first;
  } smg_cfg_t;

  typedef struct packed {
    smg_sec_t    sel;
    logic        rd;
    logic        wr;
    logic [7:0]  ofs;
    logic [7:0]  wdata;
  } smg_sec_req_t;

endpackage

// [verilog/smg_strap_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module smg_strap_decode
  import smg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       strap_config_select_i,
  input  wire logic [1:0] default_set_i,
  input  wire logic       media_iface_select_i,
  input  wire logic       link_role_select_i,
  input  wire logic       laps_encap_strap_i,
  input  wire logic       scrambler_bypass_strap_i,
  input  wire logic       bit_order_reverse_strap_i,
  output logic            hw_mode_o,
  output logic [1:0]      set_o,
  output smg_cfg_t        cfg_o,
  output logic [7:0]      txq_size_o
);

  // straps are caught once on the first edge after reset release
  logic     taken;
  logic     next_hw;
  logic [1:0] next_set;
  smg_cfg_t next_cfg;

  assign next_hw  = strap_config_select_i;
  assign next_set = default_set_i;
  assign next_cfg.rmii        = media_iface_select_i;
  assign next_cfg.dce         = link_role_select_i;
  assign next_cfg.laps_en     = laps_encap_strap_i;
  assign next_cfg.scramble_en = ~scrambler_bypass_strap_i;
  assign next_cfg.lsb_first   = bit_order_reverse_strap_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      taken     <= 1'b0;
      hw_mode_o <= 1'b0;
      set_o     <= 2'b00;
      cfg_o     <= '0;
    end else if (!taken) begin
      taken     <= 1'b1;
      hw_mode_o <= next_hw;
      set_o     <= next_set;
      cfg_o     <= next_cfg;
    end
  end

  // odd sets keep the queue size of the even set below them
  assign txq_size_o = set_o[1] ? TXQ_768 : TXQ_640;

endmodule
`default_nettype wire

// [verilog/smg_global_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module smg_global_regs
  import smg_pkg::*;
#(
  parameter logic [7:0] ID_LOW  = 8'h5a,  // arbitrary value
  parameter logic [7:0] ID_HIGH = 8'h01   // arbitrary value
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // avalon-mm slave, byte address
  input  wire logic [13:0]  avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // straps
  input  wire logic         strap_config_select_i,
  input  wire logic [1:0]   default_set_i,
  input  wire logic         media_iface_select_i,
  input  wire logic         link_role_select_i,
  input  wire logic         duplex_strap_i,
  input  wire logic         laps_encap_strap_i,
  input  wire logic         scrambler_bypass_strap_i,
  input  wire logic         bit_order_reverse_strap_i,
  // other sections
  output smg_sec_req_t      sec_req_o,
  input  wire logic [7:0]   sec_rdata_i,
  // status from the rest of the device
  input  wire logic [3:0]   clock_activity_i,
  input  wire logic [1:0]   line_irq_i,
  input  wire logic         subscriber_irq_i,
  input  wire logic [1:0]   queue_irq_i,
  input  wire logic         bit_tester_irq_i,
  input  wire logic         self_test_done_i,
  input  wire logic         self_test_pass_fail_i,
  // configuration out
  output smg_cfg_t          cfg_o,
  output logic              hw_mode_o,
  output logic [7:0]        hw_txq_size_o,
  output logic              duplex_strap_ok_o,
  output logic              soft_reset_o,
  output logic              irq_mask_o,
  output logic              ref_clock_output_enable_o,
  output logic              led_control_o,
  output logic [1:0]        line_irq_enable_o,
  output logic              subscriber_irq_enable_o,
  output logic [1:0]        queue_irq_enable_o,
  output logic              bit_tester_irq_enable_o,
  output logic              line_connect_o,
  output logic [3:0]        queue_priority_o,
  output logic              self_test_go_o,
  output logic [3:0]        sdram_burst_o,
  output logic [2:0]        sdram_latency_o,
  output logic              sdram_mode_write_o,
  output logic [7:0]        sdram_refresh_count_o
);

  function automatic smg_sec_t sec_of(input logic [11:0] idx);
    if (idx > IDX_LAST)
      sec_of = SMG_SEC_NONE;
    else if (idx < SEC_AR_LO)
      sec_of = SMG_SEC_GLOBAL;
    else if (idx < SEC_BE_LO)
      sec_of = SMG_SEC_ARBITER;
    else if (idx < SEC_SI_LO)
      sec_of = SMG_SEC_BERT;
    else if (idx < SEC_EI_LO)
      sec_of = SMG_SEC_SERIAL;
    else if (idx < SEC_UNUSED_LO)
      // only the indirect-access window; MAC registers stay unmapped
      sec_of = SMG_SEC_ETHER;
    else
      sec_of = SMG_SEC_NONE;
  endfunction

  // writable bits of each global location; zero means read-only or absent
  function automatic logic [7:0] wmask(input logic [5:0] ofs);
    case (ofs)
      OFS_GCTRL:    wmask = MSK_GCTRL;
      OFS_LED:      wmask = MSK_BIT0;
      OFS_LINE_IE:  wmask = MSK_BIT40;
      OFS_SUB_IE:   wmask = MSK_BIT0;
      OFS_QUE_IE:   wmask = MSK_BIT40;
      OFS_BT_IE:    wmask = MSK_BIT0;
      OFS_CONNECT:  wmask = MSK_BIT0;
      OFS_QPRIO:    wmask = MSK_QPRIO;
      OFS_ST_EN:    wmask = MSK_BIT0;
      OFS_SD_BURST: wmask = MSK_QPRIO;
      OFS_SD_LAT:   wmask = MSK_SD_LAT;
      OFS_SD_WS:    wmask = MSK_BIT0;
      OFS_SD_REF:   wmask = MSK_ALL;
      OFS_LINK_CFG: wmask = MSK_LINKCFG;
      default:      wmask = 8'h00;  // id bytes land here
    endcase
  endfunction

  // handshake: first cycle of a request is taken, second cycle answers;
  // writes land in the answering cycle, at the edge where the master sees the answer
  logic        ack;
  wire  logic  req      = avs_read | avs_write;
  wire  logic  take     = req & ~ack;
  wire  logic  done     = req & ack;
  wire  logic [11:0] idx = avs_address[13:2];
  wire  smg_sec_t    sec = sec_of(idx);
  wire  logic [5:0]  gofs = idx[5:0];
  wire  logic        gl_hit = (sec == SMG_SEC_GLOBAL);
  wire  logic        lane0  = avs_byteenable[0];
  wire  logic        gl_wr  = done & avs_write & gl_hit & lane0;
  wire  logic        gl_rd  = take & avs_read & gl_hit;
  wire  logic [7:0]  wbyte  = avs_writedata[7:0];

  assign avs_waitrequest = req & ~ack;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      ack <= 1'b0;
    else
      ack <= take;
  end

  // reads are forwarded in the taking cycle, writes in the answering one
  wire logic [11:0] sec_base =
    (sec == SMG_SEC_ARBITER) ? SEC_AR_LO :
    (sec == SMG_SEC_BERT)    ? SEC_BE_LO :
    (sec == SMG_SEC_SERIAL)  ? SEC_SI_LO :
    (sec == SMG_SEC_ETHER)   ? SEC_EI_LO : SEC_GL_LO;
  wire logic [11:0] sec_rel = idx - sec_base;
  wire logic        fwd = (sec != SMG_SEC_GLOBAL) & (sec != SMG_SEC_NONE);

  assign sec_req_o.sel   = fwd ? sec : SMG_SEC_NONE;
  assign sec_req_o.rd    = take & avs_read & fwd;
  assign sec_req_o.wr    = done & avs_write & fwd & lane0;
  assign sec_req_o.ofs   = sec_rel[7:0];
  assign sec_req_o.wdata = wbyte;

  // writable global registers
  logic [7:0] gctrl;
  logic [7:0] led;
  logic [7:0] line_ie;
  logic [7:0] sub_ie;
  logic [7:0] que_ie;
  logic [7:0] bt_ie;
  logic [7:0] connect;
  logic [7:0] qprio;
  logic [7:0] st_en;
  logic [7:0] sd_burst;
  logic [7:0] sd_lat;
  logic [7:0] sd_ws;
  logic [7:0] sd_ref;
  logic [7:0] link_cfg;

  wire logic [7:0] wm = wmask(gofs) & wbyte;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gctrl    <= RST_VALUE;
      led      <= RST_VALUE;
      line_ie  <= RST_VALUE;
      sub_ie   <= RST_VALUE;
      que_ie   <= RST_VALUE;
      bt_ie    <= RST_VALUE;
      connect  <= RST_VALUE;
      qprio    <= RST_VALUE;
      st_en    <= RST_VALUE;
      sd_burst <= RST_VALUE;
      sd_lat   <= RST_VALUE;
      sd_ws    <= RST_VALUE;
      sd_ref   <= RST_VALUE;
      link_cfg <= RST_VALUE;
    end else if (gl_wr) begin
      case (gofs)
        OFS_GCTRL:    gctrl    <= wm;
        OFS_LED:      led      <= wm;
        OFS_LINE_IE:  line_ie  <= wm;
        OFS_SUB_IE:   sub_ie   <= wm;
        OFS_QUE_IE:   que_ie   <= wm;
        OFS_BT_IE:    bt_ie    <= wm;
        OFS_CONNECT:  connect  <= wm;
        OFS_QPRIO:    qprio    <= wm;
        OFS_ST_EN:    st_en    <= wm;
        OFS_SD_BURST: sd_burst <= wm;
        OFS_SD_LAT:   sd_lat   <= wm;
        OFS_SD_WS:    sd_ws    <= wm;
        OFS_SD_REF:   sd_ref   <= wm;
        OFS_LINK_CFG: link_cfg <= wm;
        default:      ;  // read-only and reserved locations ignore writes
      endcase
    end
  end

  // latched clock-activity bits: line rx/tx at 4/0, sys-ref at 1/0
  logic [7:0] line_act;
  logic [7:0] sref_act;
  wire logic [7:0] line_ev = {3'b000, clock_activity_i[3], 3'b000, clock_activity_i[2]};
  wire logic [7:0] sref_ev = {6'b000000, clock_activity_i[1:0]};
  wire logic rd_line_act = gl_rd & (gofs == OFS_LINE_ACT);
  wire logic rd_sref_act = gl_rd & (gofs == OFS_SREF_ACT);

  // the read returns the value before clearing; an event in the
  // clearing cycle survives because set wins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      line_act <= RST_VALUE;
      sref_act <= RST_VALUE;
    end else begin
      line_act <= (rd_line_act ? 8'h00 : line_act) | line_ev;
      sref_act <= (rd_sref_act ? 8'h00 : sref_act) | sref_ev;
    end
  end

  // straps and hardware mode
  logic       hw_mode;
  logic [1:0] hw_set;
  smg_cfg_t   hw_cfg;
  logic [7:0] hw_txq;

  smg_strap_decode u_strap (
    .clk_i                     (clk_i),
    .reset_i                   (reset_i),
    .strap_config_select_i     (strap_config_select_i),
    .default_set_i             (default_set_i),
    .media_iface_select_i      (media_iface_select_i),
    .link_role_select_i        (link_role_select_i),
    .laps_encap_strap_i        (laps_encap_strap_i),
    .scrambler_bypass_strap_i  (scrambler_bypass_strap_i),
    .bit_order_reverse_strap_i (bit_order_reverse_strap_i),
    .hw_mode_o                 (hw_mode),
    .set_o                     (hw_set),
    .cfg_o                     (hw_cfg),
    .txq_size_o                (hw_txq)
  );

  smg_cfg_t sw_cfg;
  assign sw_cfg.rmii        = link_cfg[0];
  assign sw_cfg.dce         = link_cfg[1];
  assign sw_cfg.laps_en     = link_cfg[2];
  assign sw_cfg.scramble_en = ~link_cfg[3];
  assign sw_cfg.lsb_first   = link_cfg[4];

  // the board is trusted to strap full duplex; only reported here
  logic duplex_ok;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      duplex_ok <= 1'b0;
    else
      duplex_ok <= duplex_strap_i;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_o         <= '0;
      hw_txq_size_o <= RST_VALUE;
    end else begin
      cfg_o         <= hw_mode ? hw_cfg : sw_cfg;
      hw_txq_size_o <= hw_txq;
    end
  end

  assign hw_mode_o         = hw_mode;
  assign duplex_strap_ok_o = duplex_ok;

  // register-sourced outputs
  assign soft_reset_o              = gctrl[GC_SOFT_RST];
  assign irq_mask_o                = gctrl[GC_IRQ_MASK];
  assign ref_clock_output_enable_o = gctrl[GC_REFCLK];
  assign led_control_o             = led[0];
  assign line_irq_enable_o         = {line_ie[4], line_ie[0]};
  assign subscriber_irq_enable_o   = sub_ie[0];
  assign queue_irq_enable_o        = {que_ie[4], que_ie[0]};
  assign bit_tester_irq_enable_o   = bt_ie[0];
  assign line_connect_o            = connect[0];
  assign queue_priority_o          = qprio[3:0];
  assign self_test_go_o            = st_en[0];
  assign sdram_burst_o             = sd_burst[3:0];
  assign sdram_latency_o           = sd_lat[2:0];
  assign sdram_mode_write_o        = sd_ws[0];
  assign sdram_refresh_count_o     = sd_ref;

  // global read mux; reserved bits and locations read as zero
  logic [7:0] gl_rdata;
  always_comb begin
    gl_rdata = 8'h00;
    case (gofs)
      OFS_ID_LOW:     gl_rdata = ID_LOW;
      OFS_ID_HIGH:    gl_rdata = ID_HIGH;
      OFS_GCTRL:      gl_rdata = gctrl;
      OFS_LED:        gl_rdata = led;
      OFS_LINE_ACT:   gl_rdata = line_act;
      OFS_SREF_ACT:   gl_rdata = sref_act;
      OFS_LINE_IE:    gl_rdata = line_ie;
      OFS_LINE_IS:    gl_rdata = {3'b000, line_irq_i[1], 3'b000, line_irq_i[0]};
      OFS_SUB_IE:     gl_rdata = sub_ie;
      OFS_SUB_IS:     gl_rdata = {7'h00, subscriber_irq_i};
      OFS_QUE_IE:     gl_rdata = que_ie;
      OFS_QUE_IS:     gl_rdata = {3'b000, queue_irq_i[1], 3'b000, queue_irq_i[0]};
      OFS_BT_IE:      gl_rdata = bt_ie;
      OFS_BT_IS:      gl_rdata = {7'h00, bit_tester_irq_i};
      OFS_CONNECT:    gl_rdata = connect;
      OFS_QPRIO:      gl_rdata = qprio;
      OFS_ST_EN:      gl_rdata = st_en;
      OFS_ST_RES:     gl_rdata = {6'h00, self_test_done_i, self_test_pass_fail_i};
      OFS_SD_BURST:   gl_rdata = sd_burst;
      OFS_SD_LAT:     gl_rdata = sd_lat;
      OFS_SD_WS:      gl_rdata = sd_ws;
      OFS_SD_REF:     gl_rdata = sd_ref;
      OFS_LINK_CFG:   gl_rdata = link_cfg;
      OFS_STRAP_STAT: gl_rdata = {5'h00, hw_set, hw_mode};
      default:        gl_rdata = 8'h00;
    endcase
  end

  wire logic [7:0] any_rdata =
    gl_hit ? gl_rdata :
    fwd    ? sec_rdata_i : 8'h00;

  // read data captured at the taking edge and held through the answer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      avs_readdata <= 32'h0000_0000;
    else if (take && avs_read)
      avs_readdata <= {24'h00_0000, any_rdata};
  end

endmodule
`default_nettype wire

// [tb/smg_sec_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smg_sec_model
  import smg_pkg::*;
(
  input  wire logic         clk_i,
  input  wire smg_sec_req_t req_i,
  output logic [7:0]        rdata_o
);
  logic [7:0] mem [0:7][0:255];
  logic [7:0] idle_pat;

  // distinct contents per section, so a misrouted access returns wrong data
  initial begin
    idle_pat = 8'h5a;
    for (int s = 0; s < 8; s++) begin
      for (int o = 0; o < 256; o++) begin
        mem[s][o] = 8'(s * 37 + o);
      end
    end
  end

  always @(posedge clk_i) begin
    idle_pat <= ~idle_pat;
    if (req_i.wr && req_i.sel != SMG_SEC_NONE) begin
      mem[req_i.sel][req_i.ofs] <= req_i.wdata;
    end
  end

  // outside a read the data lines toggle, so stale data is never mistaken for an answer
  assign rdata_o = req_i.rd ? mem[req_i.sel][req_i.ofs] : idle_pat;
endmodule
`default_nettype wire

// [tb/smg_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module smg_regs_props
  import smg_pkg::*;
#(
  parameter logic [7:0] ID_LOW  = 8'h5a,
  parameter logic [7:0] ID_HIGH = 8'h01
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [13:0]  avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_readdata,
  input  wire logic         avs_waitrequest,
  input  wire logic [1:0]   default_set_i,
  input  wire logic         media_iface_select_i,
  input  wire logic         link_role_select_i,
  input  wire logic         laps_encap_strap_i,
  input  wire logic         scrambler_bypass_strap_i,
  input  wire logic         bit_order_reverse_strap_i,
  input  wire smg_sec_req_t sec_req_o,
  input  wire smg_cfg_t     cfg_o,
  input  wire logic         hw_mode_o,
  input  wire logic [7:0]   hw_txq_size_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic [11:0] idx;
  smg_sec_t    exp_sel;
  assign idx = avs_address[13:2];
  assign exp_sel = (idx < SEC_AR_LO || idx >= SEC_UNUSED_LO) ? SMG_SEC_NONE :
                   idx < SEC_BE_LO ? SMG_SEC_ARBITER : idx < SEC_SI_LO ? SMG_SEC_BERT :
                   idx < SEC_EI_LO ? SMG_SEC_SERIAL : SMG_SEC_ETHER;

  sequence take_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_take_s;
    avs_read && avs_waitrequest;
  endsequence

  answer_next_a: assert property (take_s |=> !avs_waitrequest) else $error("no answer one cycle after take");
  idle_wait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("wait while idle");
  unused_zero_a: assert property (rd_take_s ##0 (idx >= SEC_UNUSED_LO) |=> avs_readdata == 32'h0) else
    $error("unused space read not zero");
  id_value_a: assert property (rd_take_s ##0 (idx < 12'h002) |=>
    avs_readdata == {24'h0, ($past(avs_address[2]) ? ID_HIGH : ID_LOW)}) else $error("id byte wrong");
  section_route_a: assert property (take_s ##0 (exp_sel != SMG_SEC_NONE) |->
    sec_req_o.sel == exp_sel) else $error("section select wrong");
  fwd_pulse_a: assert property (take_s ##0 (exp_sel != SMG_SEC_NONE) |->
    (sec_req_o.rd == avs_read) && !sec_req_o.wr ##1 !sec_req_o.rd && (sec_req_o.wr == avs_write))
    else $error("forward pulse wrong");
  no_forward_a: assert property (take_s ##0 (exp_sel == SMG_SEC_NONE) |->
    !sec_req_o.rd && !sec_req_o.wr) else $error("global or unused access forwarded");
  strap_cfg_a: assert property (hw_mode_o && $past(hw_mode_o) |-> cfg_o == {media_iface_select_i,
    link_role_select_i, laps_encap_strap_i, !scrambler_bypass_strap_i, bit_order_reverse_strap_i})
    else $error("strap configuration wrong");
  queue_size_a: assert property (hw_mode_o && $past(hw_mode_o) |->
    hw_txq_size_o == (default_set_i[1] ? TXQ_768 : TXQ_640)) else $error("queue size code wrong");
endmodule

bind smg_global_regs smg_regs_props #(.ID_LOW(ID_LOW), .ID_HIGH(ID_HIGH)) u_props (
  .clk_i(clk_i), .reset_i(reset_i), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .default_set_i(default_set_i), .media_iface_select_i(media_iface_select_i),
  .link_role_select_i(link_role_select_i), .laps_encap_strap_i(laps_encap_strap_i),
  .scrambler_bypass_strap_i(scrambler_bypass_strap_i), .bit_order_reverse_strap_i(bit_order_reverse_strap_i),
  .sec_req_o(sec_req_o), .cfg_o(cfg_o), .hw_mode_o(hw_mode_o), .hw_txq_size_o(hw_txq_size_o));
`default_nettype wire

// [tb/test_strap_mode_and_global_register_map.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_strap_mode_and_global_register_map
  import smg_pkg::*;
;
  localparam logic [7:0] ID_L = 8'h5a;  // arbitrary value
  localparam logic [7:0] ID_H = 8'h01;  // arbitrary value
  logic clk_i, reset_i, avs_read, avs_write, avs_waitrequest, hw_i, media_i, role_i, laps_i, scr_i, bo_i;
  logic [13:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] set_i, line_irq_i, queue_irq_i;
  logic [3:0] clock_activity_i, qprio;
  logic [7:0] sec_rdata, r, v;
  logic sub_i, bt_i, done_i, pf_i;
  smg_sec_req_t sec_req;
  smg_cfg_t cfg;
  logic [7:0] txq, refc;
  int bad_count, num_checks, seed, ix;
  logic [7:0] sec_exp [int];
  logic [5:0] rw_ofs [14] = '{6'h02, 6'h03, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h12, 6'h20, 6'h3a, 6'h3b,
                              6'h3c, 6'h3d, 6'h30};
  // soft reset bit left out so the walk does not disturb its own registers
  logic [7:0] rw_msk [14] = '{8'h06, MSK_BIT0, MSK_BIT40, MSK_BIT0, MSK_BIT40, MSK_BIT0, MSK_BIT0, MSK_QPRIO,
                              MSK_BIT0, 8'h0f, MSK_SD_LAT, MSK_BIT0, MSK_ALL, MSK_LINKCFG};

  smg_global_regs #(.ID_LOW(ID_L), .ID_HIGH(ID_H)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .strap_config_select_i(hw_i), .default_set_i(set_i),
    .media_iface_select_i(media_i), .link_role_select_i(role_i), .duplex_strap_i(1'b1),
    .laps_encap_strap_i(laps_i), .scrambler_bypass_strap_i(scr_i), .bit_order_reverse_strap_i(bo_i),
    .sec_req_o(sec_req), .sec_rdata_i(sec_rdata), .clock_activity_i(clock_activity_i), .line_irq_i(line_irq_i),
    .subscriber_irq_i(sub_i), .queue_irq_i(queue_irq_i), .bit_tester_irq_i(bt_i), .self_test_done_i(done_i),
    .self_test_pass_fail_i(pf_i), .cfg_o(cfg), .hw_mode_o(), .hw_txq_size_o(txq), .duplex_strap_ok_o(),
    .soft_reset_o(), .irq_mask_o(), .ref_clock_output_enable_o(), .led_control_o(), .line_irq_enable_o(),
    .subscriber_irq_enable_o(), .queue_irq_enable_o(), .bit_tester_irq_enable_o(), .line_connect_o(),
    .queue_priority_o(qprio), .self_test_go_o(), .sdram_burst_o(), .sdram_latency_o(), .sdram_mode_write_o(),
    .sdram_refresh_count_o(refc));
  smg_sec_model u_sec (.clk_i(clk_i), .req_i(sec_req), .rdata_o(sec_rdata));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    avs_address <= {a, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin @(posedge clk_i); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin bad_count++; summarize(); end
    rd = avs_readdata[7:0]; // upper lanes are never looked at
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic do_reset(input logic hw);
    reset_i <= 1'b1;
    hw_i <= hw;
    {set_i, media_i, role_i, laps_i, scr_i, bo_i} <= 7'($random(seed));
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, clock_activity_i} = '0;
    {line_irq_i, queue_irq_i, sub_i, bt_i, done_i, pf_i} = '0;
    reset_i = 1'b1;
    bad_count = 0;
    num_checks = 0;
    seed = 15;
    for (int k = 0; k < 4; k++) begin
      do_reset(k != 3);
      if (k != 3) begin
        `CHK("cfg", {media_i, role_i, laps_i, !scr_i, bo_i}, cfg)
        `CHK("txq", (set_i[1] ? TXQ_768 : TXQ_640), txq)
      end
      bus(1'b0, 12'h031, 8'h00, r);
      `CHK("strap status", {5'h0, set_i, hw_i}, r)
    end
    for (int i = 0; i < 14; i++) begin
      bus(1'b0, {6'h0, rw_ofs[i]}, 8'h00, r);
      `CHK("reset value", RST_VALUE, r)
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 12'(i), 8'hff, r);
      bus(1'b0, 12'(i), 8'h00, r);
      `CHK("id", (i == 0 ? ID_L : ID_H), r)
    end
    for (int i = 0; i < 14; i++) begin
      v = 8'($random(seed)) & rw_msk[i];
      bus(1'b1, {6'h0, rw_ofs[i]}, v, r);
      bus(1'b0, {6'h0, rw_ofs[i]}, 8'h00, r);
      `CHK("rw reg", v, r)
      if (rw_ofs[i] == 6'h12) `CHK("qprio", v[3:0], qprio)
      if (rw_ofs[i] == 6'h3d) `CHK("refresh", v, refc)
    end
    `CHK("sw cfg", {v[0], v[1], v[2], !v[3], v[4]}, cfg)
    for (int i = 0; i < 6; i++) begin
      ix = (i == 0) ? 'h180 : (i == 1) ? 'h7ff : (i == 2) ? 'h8ff : (i == 3) ? 'h900 : (i == 4) ? 'hfff : 'h00f;
      bus(1'b1, 12'(ix), 8'h00, r); // reserved locations only ever get zero
      bus(1'b0, 12'(ix), 8'h00, r);
      `CHK("unused", 8'h00, r)
    end
    for (int i = 0; i < 8; i++) begin
      ix = 'h40 + ($unsigned($random(seed)) % 'h140);
      if (!sec_exp.exists(ix)) sec_exp[ix] = 8'((ix < 'h80 ? 1 : ix < 'hc0 ? 2 : ix < 'h140 ? 3 : 4) * 37 + ix -
        (ix < 'h80 ? 'h40 : ix < 'hc0 ? 'h80 : ix < 'h140 ? 'hc0 : 'h140));
      bus(1'b0, 12'(ix), 8'h00, r);
      `CHK("section rd", sec_exp[ix], r)
      sec_exp[ix] = 8'($random(seed));
      bus(1'b1, 12'(ix), sec_exp[ix], r);
      bus(1'b0, 12'(ix), 8'h00, r);
      `CHK("section wr", sec_exp[ix], r)
    end
    @(posedge clk_i);
    clock_activity_i <= 4'hf;
    @(posedge clk_i);
    clock_activity_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, 12'h004, 8'h00, r);
      `CHK("line act", (i == 0 ? 8'h11 : 8'h00), r)
      bus(1'b0, 12'h005, 8'h00, r);
      `CHK("ref act", (i == 0 ? 8'h03 : 8'h00), r)
    end
    {line_irq_i, queue_irq_i, sub_i, bt_i, done_i, pf_i} <= 8'($random(seed));
    bus(1'b0, 12'h009, 8'h00, r);
    `CHK("sub status", {7'h0, sub_i}, r)
    bus(1'b0, 12'h007, 8'h00, r);
    `CHK("line status", {3'h0, line_irq_i[1], 3'h0, line_irq_i[0]}, r)
    bus(1'b0, 12'h00b, 8'h00, r);
    `CHK("queue status", {3'h0, queue_irq_i[1], 3'h0, queue_irq_i[0]}, r)
    bus(1'b0, 12'h00d, 8'h00, r);
    `CHK("bt status", {7'h0, bt_i}, r)
    bus(1'b0, 12'h021, 8'h00, r);
    `CHK("self test", {6'h0, done_i, pf_i}, r)
    summarize();
  end

  initial begin
    repeat (50000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
